// ---- rtl/lfh_pkg.sv ----
// lfh_pkg: shared constants and carriers for the lpc flash host interface
// assumes: one 250 mhz core clock, lpc pins sampled through synchronisers
package lfh_pkg;
   // ---------------------------------------------------------------
   // lpc encodings
   // ---------------------------------------------------------------
   localparam logic [3:0] LFH_START_MEM = 4'h0;
   localparam logic [3:0] LFH_ABORT = 4'hf;
   localparam logic [3:0] LFH_CYC_READ = 4'h4;
   localparam logic [3:0] LFH_CYC_WRITE = 4'h6;
   localparam logic [3:0] LFH_SYNC_READY = 4'h0;
   localparam logic [3:0] LFH_SYNC_WAIT = 4'h5;
   localparam int LFH_ADDR_NIBBLES = 8;
   localparam int LFH_TAR_CLOCKS = 2;
   // ---------------------------------------------------------------
   // memory map
   // ---------------------------------------------------------------
   localparam int LFH_AW = 18;
   localparam logic [31:0] LFH_GIN_ADDR = 32'hffbc0100;
   localparam logic [LFH_AW-1:0] LFH_BOOT_BASE = 18'h3c000;
   localparam int LFH_GIN_BITS = 5;
   localparam int LFH_PP_AW = 11;
   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int LFH_CLK_MHZ = 250;
   localparam int LFH_PROG_MAX_US = 20;
   localparam int LFH_PROG_CYCLES = LFH_PROG_MAX_US * LFH_CLK_MHZ;
   localparam int LFH_ERASE_CYCLES = 8192;
   localparam int LFH_RST_LAT_CYCLES = 64;
   // ---------------------------------------------------------------
   // carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [LFH_AW-1:0] addr;
      logic [7:0] data;
      logic erase;
   } lfh_wr_t;
   typedef enum logic [8:0] {
      ST_IDLE = 9'h001, ST_START = 9'h002, ST_CYC = 9'h004,
      ST_ADDR = 9'h008, ST_WDATA = 9'h010, ST_TAR1 = 9'h020,
      ST_SYNC = 9'h040, ST_RDATA = 9'h080, ST_WAITAB = 9'h100
   } lfh_state_t;
endpackage

// ---- rtl/lfh_nvm_core.sv ----
// lfh_nvm_core: byte array with internal program/erase timer
// assumes: writes arrive already filtered by the protection pins
module lfh_nvm_core
   import lfh_pkg::*;
#(
   parameter int PROG_CYCLES = LFH_PROG_CYCLES,
   parameter int ERASE_CYCLES = LFH_ERASE_CYCLES,
   parameter int DEPTH = 1 << LFH_AW
) (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic wr_i,
   input wire lfh_wr_t wr_req_i,
   input wire logic [LFH_AW-1:0] rd_addr_i,
   output logic [7:0] rd_data_o,
   output logic prog_busy_o,
   output logic erase_busy_o
);
   logic [7:0] mem [DEPTH];
   logic [31:0] cnt_q;
   lfh_wr_t op_q;
   logic busy_q;

   // ---------------------------------------------------------------
   // timed operation; reset aborts, contents left as they stood
   // ---------------------------------------------------------------
   // fixed program time
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         busy_q <= 1'b0;
         cnt_q <= 32'h0;
         op_q <= '0;
      end else if (!busy_q && wr_i) begin
         busy_q <= 1'b1;
         op_q <= wr_req_i;
         cnt_q <= wr_req_i.erase ? 32'(ERASE_CYCLES - 1)
                                 : 32'(PROG_CYCLES - 1);
      end else if (busy_q) begin
         if (cnt_q == 32'h0) busy_q <= 1'b0;
         else cnt_q <= cnt_q - 32'h1;
      end
   end

   // array starts erased and is not touched by reset, like real cells
   initial begin
      for (int i = 0; i < DEPTH; i++)
         mem[i] = 8'hff;
   end

   // array written on completion; a sector erase clears 4 kbytes
   // plain always: the power-up fill above writes the array as well
   always @(posedge clock_i) begin
      if (busy_q && cnt_q == 32'h0) begin
         if (op_q.erase) begin
            for (int i = 0; i < 4096; i++)
               mem[{op_q.addr[LFH_AW-1:12], 12'(i)}] <= 8'hff;
         end else begin
            mem[op_q.addr] <= mem[op_q.addr] & op_q.data;
         end
      end
   end

   always_comb begin
      rd_data_o = mem[rd_addr_i];
      if (busy_q && op_q.erase) rd_data_o[7] = 1'b0;
      else if (busy_q) rd_data_o[7] = ~op_q.data[7];
   end
   assign prog_busy_o = busy_q && !op_q.erase;
   assign erase_busy_o = busy_q && op_q.erase;

   prog_bound_a: assert property (@(posedge clock_i)
      disable iff (!nrst_i)
      $rose(busy_q) && !op_q.erase |-> cnt_q <= 32'(PROG_CYCLES - 1))
      else $error("program time above limit");
endmodule

// ---- rtl/lfh_lpc_flash.sv ----
// lfh_lpc_flash: lpc memory target of a byte-wide flash with pp mode
// assumes: host lpc clock is slower than clock_i and comes in as a pin
module lfh_lpc_flash
   import lfh_pkg::*;
#(
   parameter int PROG_CYCLES = LFH_PROG_CYCLES,
   parameter int ERASE_CYCLES = LFH_ERASE_CYCLES
) (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic init_n_i,
   input wire logic parallel_programming_mode_i,
   input wire logic lpc_clk_i,
   input wire logic lframe_n_i,
   input wire logic ce_n_i,
   input wire logic [3:0] lad_i,
   output logic [3:0] lad_o,
   output logic [3:0] lad_oe_n_o,
   input wire logic top_boot_lock_n_i,
   input wire logic wp_n_i,
   input wire logic [LFH_GIN_BITS-1:0] general_input_i,
   input wire logic [LFH_PP_AW-1:0] pp_addr_i,
   input wire logic pp_row_col_i,
   input wire logic pp_we_n_i,
   input wire logic pp_oe_n_i,
   input wire logic [7:0] pp_data_i,
   output logic [7:0] pp_data_o,
   output logic pp_data_oe_n_o,
   output logic busy_o
);
   // ---------------------------------------------------------------
   // reset merge and latency
   // ---------------------------------------------------------------
   // both pins equal
   logic rst_n;
   assign rst_n = nrst_i & init_n_i;
   logic prog_busy, erase_busy;
   logic [6:0] rlat_q;
   logic was_busy_q;
   // core aborted, fixed latency after every reset
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) rlat_q <= 7'(LFH_RST_LAT_CYCLES);
      else if (rlat_q != 7'h0) rlat_q <= rlat_q - 7'h1;
   end
   logic ready;
   assign ready = (rlat_q == 7'h0);

   // ---------------------------------------------------------------
   // pin synchronisers, three stages
   // ---------------------------------------------------------------
   localparam int SW = 1 + 1 + 1 + 4 + 1 + 1 + 1;
   logic [SW-1:0] s1_q, s2_q, s3_q, pin_q;
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         s1_q <= '1;
         s2_q <= '1;
         s3_q <= '1;
         pin_q <= '1;
      end else begin
         s1_q <= {lpc_clk_i, lframe_n_i, ce_n_i, lad_i, pp_row_col_i,
                  pp_we_n_i, pp_oe_n_i};
         s2_q <= s1_q;
         s3_q <= s2_q;
         for (int b = 0; b < SW; b++)
            if (s2_q[b] == s3_q[b]) pin_q[b] <= s3_q[b];
      end
   end
   logic lclk, lframe_n, ce_n, row_col, we_n, oe_n;
   logic [3:0] lad;
   assign {lclk, lframe_n, ce_n, lad, row_col, we_n, oe_n} = pin_q;
   logic lclk_d_q;
   always_ff @(posedge clock_i or negedge rst_n) begin
      // matches the synchroniser reset level: no false edge after reset
      if (!rst_n) lclk_d_q <= 1'b1;
      else lclk_d_q <= lclk;
   end
   // one sample per lpc rising edge
   logic lrise;
   assign lrise = lclk & ~lclk_d_q;
   logic mode_pp;
   assign mode_pp = parallel_programming_mode_i;

   // ---------------------------------------------------------------
   // protection check
   // ---------------------------------------------------------------
   function automatic logic wr_allowed(input logic [LFH_AW-1:0] a);
      if (a >= LFH_BOOT_BASE) return top_boot_lock_n_i;
      return wp_n_i;
   endfunction

   // ---------------------------------------------------------------
   // lpc cycle engine
   // ---------------------------------------------------------------
   lfh_state_t st_q;
   logic [3:0] start_q;
   logic is_wr_q;
   logic [31:0] addr_q;
   logic [2:0] ncnt_q;
   logic [7:0] data_q;
   logic tar_q;
   logic lpc_wr;
   lfh_wr_t lpc_req;
   logic [7:0] mem_rd;
   logic gin_hit;
   assign gin_hit = (addr_q == LFH_GIN_ADDR);

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ST_IDLE;
         start_q <= 4'hf;
         is_wr_q <= 1'b0;
         addr_q <= 32'h0;
         ncnt_q <= 3'h0;
         data_q <= 8'h0;
         tar_q <= 1'b0;
      end else if (mode_pp || !ready) begin
         st_q <= ST_IDLE;
      end else if (lrise) begin
         if (!lframe_n) begin
            // framing restarts or aborts any cycle
            start_q <= lad;
            if (st_q == ST_IDLE || st_q == ST_START || st_q == ST_CYC)
               st_q <= ST_START;
            else if (lad == LFH_ABORT) st_q <= ST_IDLE;
            else st_q <= ST_WAITAB;
         end else begin
            case (st_q)
               ST_IDLE: st_q <= ST_IDLE;
               ST_START: begin
                  if (start_q == LFH_START_MEM && !ce_n &&
                      (lad == LFH_CYC_READ || lad == LFH_CYC_WRITE)) begin
                     is_wr_q <= (lad == LFH_CYC_WRITE);
                     ncnt_q <= 3'(LFH_ADDR_NIBBLES - 1);
                     st_q <= ST_ADDR;
                  end else st_q <= ST_IDLE;
               end
               ST_CYC: st_q <= ST_IDLE;
               ST_ADDR: begin
                  addr_q <= {addr_q[27:0], lad};
                  ncnt_q <= ncnt_q - 3'h1;
                  tar_q <= 1'b0;
                  // write data directly, read turns around
                  if (ncnt_q == 3'h0)
                     st_q <= is_wr_q ? ST_WDATA : ST_TAR1;
               end
               ST_WDATA: begin
                  data_q <= {lad, data_q[7:4]};
                  tar_q <= ~tar_q;
                  if (tar_q) st_q <= ST_TAR1;
               end
               ST_TAR1: begin
                  tar_q <= ~tar_q;
                  if (tar_q) begin
                     st_q <= ST_SYNC;
                     // live input pins; writes keep their data
                     if (!is_wr_q)
                        data_q <= gin_hit ? {3'h0, general_input_i} : mem_rd;
                  end
               end
               ST_SYNC: begin
                  tar_q <= 1'b0;
                  if (!(is_wr_q && (prog_busy || erase_busy)))
                     st_q <= is_wr_q ? ST_CYC : ST_RDATA;
               end
               ST_RDATA: begin
                  tar_q <= ~tar_q;
                  data_q <= {4'h0, data_q[7:4]};
                  if (tar_q) st_q <= ST_CYC;
               end
               ST_WAITAB: st_q <= ST_WAITAB;
               default: st_q <= ST_IDLE;
            endcase
         end
      end
   end

   // final two-clock turnaround is ST_CYC plus the idle edge after it
   // write issue: one pulse when write sync completes
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         lpc_wr <= 1'b0;
         lpc_req <= '0;
      end else begin
         lpc_wr <= lrise && lframe_n && st_q == ST_SYNC && is_wr_q &&
                   !prog_busy && !erase_busy && !gin_hit &&
                   wr_allowed(addr_q[LFH_AW-1:0]);
         lpc_req <= '{addr: addr_q[LFH_AW-1:0], data: data_q,
                      erase: 1'b0};
      end
   end

   // ---------------------------------------------------------------
   // lad drive, active-low enables
   // ---------------------------------------------------------------
   // reset clears drive at once
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         lad_o <= 4'h0;
         lad_oe_n_o <= 4'hf;
      end else if (st_q == ST_SYNC) begin
         lad_oe_n_o <= 4'h0;
         lad_o <= (is_wr_q && (prog_busy || erase_busy)) ?
                  LFH_SYNC_WAIT : LFH_SYNC_READY;
      end else if (st_q == ST_RDATA) begin
         lad_oe_n_o <= 4'h0;
         lad_o <= data_q[3:0];
      end else if (st_q == ST_CYC) begin
         lad_oe_n_o <= 4'h0;
         lad_o <= 4'hf;
      end else begin
         lad_oe_n_o <= 4'hf;
         lad_o <= 4'h0;
      end
   end

   // ---------------------------------------------------------------
   // parallel port
   // ---------------------------------------------------------------
   logic [LFH_AW-1:0] pp_addr_q;
   logic we_d_q;
   logic pp_wr;
   // row to upper bits, column to lower
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         pp_addr_q <= '0;
         we_d_q <= 1'b1;
      end else begin
         we_d_q <= we_n;
         if (!row_col)
            pp_addr_q[LFH_AW-1:LFH_AW-7] <= pp_addr_i[6:0];
         else pp_addr_q[LFH_PP_AW-1:0] <= pp_addr_i;
      end
   end
   // pp engine only in pp mode
   assign pp_wr = mode_pp && ready && we_n && !we_d_q &&
                  wr_allowed(pp_addr_q);
   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         pp_data_o <= 8'h0;
         pp_data_oe_n_o <= 1'b1;
         busy_o <= 1'b0;
      end else begin
         pp_data_o <= mem_rd;
         pp_data_oe_n_o <= !(mode_pp && !oe_n && !ce_n);
         busy_o <= prog_busy | erase_busy;
      end
   end

   logic core_wr;
   lfh_wr_t core_req;
   logic [LFH_AW-1:0] rd_addr;
   assign core_wr = mode_pp ? pp_wr : lpc_wr;
   assign core_req = mode_pp ? lfh_wr_t'{addr: pp_addr_q, data: pp_data_i,
                                         erase: 1'b0} : lpc_req;
   assign rd_addr = mode_pp ? pp_addr_q : addr_q[LFH_AW-1:0];

   lfh_nvm_core #(
      .PROG_CYCLES(PROG_CYCLES),
      .ERASE_CYCLES(ERASE_CYCLES)
   ) u_core (
      .clock_i(clock_i),
      .nrst_i(rst_n),
      .wr_i(core_wr),
      .wr_req_i(core_req),
      .rd_addr_i(rd_addr),
      .rd_data_o(mem_rd),
      .prog_busy_o(prog_busy),
      .erase_busy_o(erase_busy)
   );

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   lad_release_a: assert property (@(posedge clock_i)
      disable iff (!rst_n) st_q == ST_IDLE && $past(st_q) == ST_IDLE
      |=> lad_oe_n_o == 4'hf) else $error("lad driven while idle");
   boot_lock_a: assert property (@(posedge clock_i)
      disable iff (!rst_n) lpc_wr && !mode_pp
      |-> $past(top_boot_lock_n_i) || lpc_req.addr < LFH_BOOT_BASE)
      else $error("write into locked boot region");
   wp_guard_a: assert property (@(posedge clock_i)
      disable iff (!rst_n) lpc_wr && !mode_pp
      |-> $past(wp_n_i) || lpc_req.addr >= LFH_BOOT_BASE)
      else $error("write into protected region");
   mode_pp_a: assert property (@(posedge clock_i)
      disable iff (!rst_n) mode_pp |=> st_q == ST_IDLE)
      else $error("lpc engine active in pp mode");
   bad_start_a: assert property (@(posedge clock_i)
      disable iff (!rst_n) st_q == ST_START && lrise && lframe_n &&
      start_q != LFH_START_MEM |=> st_q == ST_IDLE)
      else $error("bad start accepted");
   abort_go_a: assert property (@(posedge clock_i)
      disable iff (!rst_n) ready && !mode_pp && lrise && !lframe_n &&
      !(st_q inside {ST_IDLE, ST_START, ST_CYC})
      |=> st_q == ST_WAITAB || st_q == ST_IDLE)
      else $error("frame did not end cycle");
   wr_dir_a: assert property (@(posedge clock_i)
      disable iff (!rst_n) st_q == ST_ADDR && is_wr_q && $changed(st_q)
      |-> $past(st_q) == ST_START)
      else $error("address phase entered oddly");
   rlat_a: assert property (@(posedge clock_i)
      $rose(rst_n) |-> !ready [*8])
      else $error("no latency after reset");
endmodule

// ---- sim/lfh_host_model.sv ----
// lfh_host_model: behavioural lpc host that frames cycles to the target
// assumes: lad_w_i is the resolved bus with pull-ups, clock_i is the core
module lfh_host_model
   import lfh_pkg::*;
(
   input wire logic clock_i,
   input wire logic [3:0] lad_w_i,
   output logic lpc_clk_o,
   output logic lframe_n_o,
   output logic ce_n_o,
   output logic [3:0] lad_o,
   output logic lad_en_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] smp;
   initial begin
      idle();
      ce_n_o = 1'b1;
   end
   task automatic idle();
      lpc_clk_o = 1'b0;
      lframe_n_o = 1'b1;
      lad_o = 4'hf;
      lad_en_o = 1'b0;
   endtask
   // ---------------------------------------------------------------
   // one lpc clock; it stands still between cycles
   // ---------------------------------------------------------------
   task automatic clk1(input logic fr, input logic [3:0] v, input logic en);
      lframe_n_o = fr;
      lad_o = v;
      lad_en_o = en;
      lpc_clk_o = 1'b0;
      repeat (8) @(negedge clock_i);
      lpc_clk_o = 1'b1;
      smp = lad_w_i;
      repeat (8) @(negedge clock_i);
   endtask
   // ---------------------------------------------------------------
   // one memory cycle; ab aborts after that many address nibbles
   // ---------------------------------------------------------------
   task automatic xfer(input bit wr, input logic [3:0] s0,
      input logic [3:0] s1, input bit ce, input int ab,
      input logic [31:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic [3:0] sy);
      int n;
      q = 8'hff;
      sy = 4'hf;
      ce_n_o = ce;
      clk1(1'b1, 4'hf, 1'b0);
      clk1(1'b0, s0, 1'b1);
      clk1(1'b0, s1, 1'b1);
      clk1(1'b1, wr ? LFH_CYC_WRITE : LFH_CYC_READ, 1'b1);
      for (int i = 7; i >= 0; i--) begin
         if (ab != 0 && ab == 7 - i) begin
            clk1(1'b0, LFH_ABORT, 1'b1);
            clk1(1'b1, 4'hf, 1'b0);
            return;
         end
         clk1(1'b1, a[i*4 +: 4], 1'b1);
      end
      if (wr) begin
         clk1(1'b1, d[3:0], 1'b1);
         clk1(1'b1, d[7:4], 1'b1);
      end
      clk1(1'b1, 4'hf, 1'b1);
      clk1(1'b1, 4'hf, 1'b0);
      clk1(1'b1, 4'hf, 1'b0);
      sy = smp;
      n = 0;
      while (smp === LFH_SYNC_WAIT && n < 200) begin
         clk1(1'b1, 4'hf, 1'b0);
         n++;
      end
      if (!wr) begin
         clk1(1'b1, 4'hf, 1'b0);
         q[3:0] = smp;
         clk1(1'b1, 4'hf, 1'b0);
         q[7:4] = smp;
      end
      clk1(1'b1, 4'hf, 1'b0);
      clk1(1'b1, 4'hf, 1'b0);
   endtask
endmodule

// ---- sim/testbench.sv ----
// testbench: self-checking bench for the lpc flash target
// assumes: lfh_host_model drives the lpc side, pull-ups on lad
module testbench
   import lfh_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int prog_cyc = 400;
   typedef struct packed {
      logic wr;
      logic [31:0] a;
      logic [7:0] d;
      logic tl;
      logic wp;
      logic [7:0] e;
   } lfh_row_t;
   localparam lfh_row_t rows [14] = '{
      '{1'b1, 32'hfffc0010, 8'h5a, 1'b1, 1'b1, 8'h00},
      '{1'b0, 32'hfffc0010, 8'h00, 1'b1, 1'b1, 8'h5a},
      '{1'b1, 32'hffffc000, 8'ha5, 1'b1, 1'b1, 8'h00},
      '{1'b0, 32'hffffc000, 8'h00, 1'b1, 1'b1, 8'ha5},
      '{1'b1, 32'hffffc000, 8'h11, 1'b0, 1'b1, 8'h00},
      '{1'b0, 32'hffffc000, 8'h00, 1'b0, 1'b1, 8'ha5},
      '{1'b1, 32'hfffc0010, 8'h22, 1'b1, 1'b0, 8'h00},
      '{1'b0, 32'hfffc0010, 8'h00, 1'b1, 1'b0, 8'h5a},
      '{1'b1, 32'hffffffff, 8'h33, 1'b1, 1'b0, 8'h00},
      '{1'b0, 32'hffffffff, 8'h00, 1'b1, 1'b0, 8'h33},
      '{1'b1, 32'hffffbfff, 8'h44, 1'b0, 1'b1, 8'h00},
      '{1'b0, 32'hffffbfff, 8'h00, 1'b0, 1'b1, 8'h44},
      '{1'b1, LFH_GIN_ADDR, 8'hff, 1'b1, 1'b1, 8'h00},
      '{1'b0, LFH_GIN_ADDR, 8'h00, 1'b1, 1'b1, 8'h15}};
   logic clock_i = 1'b0;
   logic nrst = 1'b0;
   logic init_n = 1'b1;
   logic mode = 1'b0;
   logic top_boot_lock_n = 1'b1;
   logic wp_n = 1'b1;
   logic [4:0] gin = 5'h15;
   logic [10:0] pp_addr = 11'h000;
   logic pp_rc = 1'b0;
   logic pp_we_n = 1'b1;
   logic pp_oe_n = 1'b1;
   logic [7:0] pp_data = 8'h00;
   logic lpc_clk, lframe_n, ce_n, h_en, busy_o, pp_data_oe_n_o;
   int n_drv = 0;
   int drv0;
   logic [3:0] h_lad, lad_o, lad_oe_n_o, lad_w, sy;
   logic [7:0] pp_data_o, q;
   int n_fail = 0;
   int check_count = 0;
   int k;
   always #2 clock_i = ~clock_i;
   assign lad_w = (~lad_oe_n_o & lad_o) | (lad_oe_n_o & (h_en ? h_lad : 4'hf));
   always @(posedge clock_i) begin
      if (lad_oe_n_o !== 4'hf) n_drv <= n_drv + 1;
   end
   lfh_host_model i_host (.clock_i(clock_i), .lad_w_i(lad_w),
      .lpc_clk_o(lpc_clk), .lframe_n_o(lframe_n), .ce_n_o(ce_n),
      .lad_o(h_lad), .lad_en_o(h_en));
   lfh_lpc_flash #(.PROG_CYCLES(prog_cyc), .ERASE_CYCLES(30)) i_dut (
      .clock_i(clock_i), .nrst_i(nrst), .init_n_i(init_n),
      .parallel_programming_mode_i(mode), .lpc_clk_i(lpc_clk),
      .lframe_n_i(lframe_n), .ce_n_i(ce_n), .lad_i(lad_w), .lad_o(lad_o),
      .lad_oe_n_o(lad_oe_n_o), .top_boot_lock_n_i(top_boot_lock_n),
      .wp_n_i(wp_n), .general_input_i(gin), .pp_addr_i(pp_addr),
      .pp_row_col_i(pp_rc), .pp_we_n_i(pp_we_n), .pp_oe_n_i(pp_oe_n),
      .pp_data_i(pp_data), .pp_data_o(pp_data_o),
      .pp_data_oe_n_o(pp_data_oe_n_o), .busy_o(busy_o));
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      if (n_fail == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic wait_idle();
      k = 0;
      while (busy_o !== 1'b0 && k < 2000) begin
         @(negedge clock_i);
         k++;
      end
   endtask
   // reset latency of 64 clocks plus pin synchronisers
   // reset held eight clocks
   task automatic rst_pulse(input bit use_init);
      @(negedge clock_i);
      if (use_init)
         init_n = 1'b0;
      else
         nrst = 1'b0;
      repeat (8) @(negedge clock_i);
      nrst = 1'b1;
      init_n = 1'b1;
      repeat (80) @(negedge clock_i);
   endtask
   task automatic rd(input logic [31:0] a, input logic [7:0] e);
      i_host.xfer(1'b0, 4'h0, 4'h0, 1'b0, 0, a, 8'h00, q, sy);
      chk(q, e);
   endtask
   initial begin
      #300us;
      n_fail++;
      final_report();
   end
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (4) @(negedge clock_i);
      chk({4'h0, lad_oe_n_o}, 8'h0f);
      chk({7'h0, busy_o}, 8'h00);
      chk({7'h0, pp_data_oe_n_o}, 8'h01);
      repeat (4) @(negedge clock_i);
      nrst = 1'b1;
      repeat (80) @(negedge clock_i);
      for (int r = 0; r < 14; r++) begin
         wait_idle();
         top_boot_lock_n = rows[r].tl;
         wp_n = rows[r].wp;
         i_host.xfer(rows[r].wr, 4'h0, 4'h0, 1'b0, 0, rows[r].a, rows[r].d,
            q, sy);
         chk({4'h0, sy}, 8'h00);
         if (!rows[r].wr) chk(q, rows[r].e);
      end
      wait_idle();
      i_host.xfer(1'b0, 4'h2, 4'h0, 1'b0, 0, 32'hfffc0010, 8'h00, q, sy);
      chk(q, 8'h5a);
      drv0 = n_drv;
      i_host.xfer(1'b0, 4'h0, 4'h2, 1'b0, 0, 32'hfffc0010, 8'h00, q, sy);
      i_host.xfer(1'b0, 4'h0, 4'h0, 1'b1, 0, 32'hfffc0010, 8'h00, q, sy);
      chk({7'h0, 1'(n_drv != drv0)}, 8'h00);
      i_host.xfer(1'b0, 4'h0, 4'h0, 1'b0, 4, 32'hfffc0010, 8'h00, q, sy);
      rd(32'hfffc0010, 8'h5a);
      // second write waits in sync; its data has bit 7 set
      i_host.xfer(1'b1, 4'h0, 4'h0, 1'b0, 0, 32'hfffc0100, 8'h81, q, sy);
      i_host.xfer(1'b1, 4'h0, 4'h0, 1'b0, 0, 32'hfffc0101, 8'hfe, q, sy);
      chk({4'h0, sy}, {4'h0, LFH_SYNC_WAIT});
      rd(32'hfffc0101, 8'h7f);
      wait_idle();
      chk({7'h0, 1'(k <= prog_cyc)}, 8'h01);
      rd(32'hfffc0101, 8'hfe);
      rd(32'hfffc0100, 8'h81);
      i_host.xfer(1'b1, 4'h0, 4'h0, 1'b0, 0, 32'hfffc0200, 8'h12, q, sy);
      @(negedge clock_i);
      nrst = 1'b0;
      repeat (2) @(negedge clock_i);
      chk({7'h0, busy_o}, 8'h00);
      rst_pulse(1'b0);
      for (int p = 0; p < 2; p++) begin
         fork
            i_host.xfer(1'b0, 4'h0, 4'h0, 1'b0, 0, 32'hfffc0010, 8'h00, q, sy);
         join_none
         k = 0;
         while (lad_oe_n_o === 4'hf && k < 4000) begin
            @(negedge clock_i);
            k++;
         end
         if (p == 1)
            init_n = 1'b0;
         else
            nrst = 1'b0;
         repeat (2) @(negedge clock_i);
         chk({4'h0, lad_oe_n_o}, 8'h0f);
         disable fork;
         i_host.idle();
         rst_pulse(p == 1);
      end
      mode = 1'b1;
      rst_pulse(1'b0);
      drv0 = n_drv;
      i_host.xfer(1'b0, 4'h0, 4'h0, 1'b0, 0, 32'hfffc0010, 8'h00, q, sy);
      chk({7'h0, 1'(n_drv != drv0)}, 8'h00);
      pp_rc = 1'b0;
      repeat (4) @(negedge clock_i);
      pp_rc = 1'b1;
      // column only once the synchronised row select has risen
      repeat (8) @(negedge clock_i);
      pp_addr = 11'h010;
      pp_oe_n = 1'b0;
      repeat (12) @(negedge clock_i);
      chk({7'h0, pp_data_oe_n_o}, 8'h00);
      chk(pp_data_o, 8'h5a);
      pp_data = 8'h0f;
      pp_we_n = 1'b0;
      repeat (8) @(negedge clock_i);
      pp_we_n = 1'b1;
      repeat (12) @(negedge clock_i);
      wait_idle();
      repeat (8) @(negedge clock_i);
      chk(pp_data_o, 8'h0a);
      final_report();
   end
endmodule
